// ===== src/wss_pkg.sv
package wss_pkg;

   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int unsigned WSS_CLK_HZ        = 20000000;
   localparam int unsigned WSS_WAKE_PULSE_MS = 1000;
   localparam int unsigned WSS_WAKE_CYC      = WSS_CLK_HZ / 1000 * WSS_WAKE_PULSE_MS;

   // ************************************************************
   // Register map (byte addresses, word aligned)
   // ************************************************************
   localparam logic [7:0] WSS_CFG_OFS   = 8'h00;
   localparam logic [7:0] WSS_CTRL_OFS  = 8'h04;
   localparam logic [7:0] WSS_STAT_OFS  = 8'h08;
   localparam logic [7:0] WSS_IRQ_OFS   = 8'h0c;
   localparam logic [7:0] WSS_MASK_OFS  = 8'h10;
   localparam logic [7:0] WSS_CMD_OFS   = 8'h14;

   // Config bits (nonvolatile in the real part, take effect on restart)
   localparam int WSS_CFG_HOTPLUG = 0;
   localparam int WSS_CFG_INVERT  = 1;
   localparam int WSS_CFG_WAKE    = 2;
   localparam int WSS_CFG_KILL    = 3;
   localparam logic [3:0] WSS_CFG_RST = 4'h1;

   // Control bits
   localparam int WSS_CTRL_RF_ON   = 0;
   localparam int WSS_CTRL_CLKREQ  = 1;
   localparam int WSS_CTRL_PEWAKE  = 2;
   localparam int WSS_CTRL_CDUMP   = 3;
   localparam logic [3:0] WSS_CTRL_RST = 4'h0;

   // Command bits (write one to fire)
   localparam int WSS_CMD_WAKE    = 0;
   localparam int WSS_CMD_RESTART = 1;

   // Event bits, shared by irq status and mask
   localparam int WSS_EV_INSERT  = 0;
   localparam int WSS_EV_REMOVE  = 1;
   localparam int WSS_EV_KILL    = 2;
   localparam int WSS_EV_BACKOFF = 3;
   localparam int WSS_EV_CLKREQ  = 4;
   localparam int WSS_EV_W       = 5;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic kill_en;
      logic wake_en;
      logic invert;
      logic hotplug;
   } wss_cfg_t;

   typedef struct packed {
      logic card_present;
      logic radio_off;
      logic backoff;
      logic clkreq_line;
   } wss_sense_t;

   typedef enum logic [1:0] {
      WSS_W_IDLE  = 2'b00,
      WSS_W_PULSE = 2'b01
   } wss_wake_st_t;

endpackage : wss_pkg

// ===== src/wss_sync.sv
`timescale 1ns/100ps
module wss_sync
   import wss_pkg::*;
#(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         rst_b_in,
   // Async level and synchronised copy
   input  wire logic [W-1:0] async_in,
   input  wire logic [W-1:0] rst_val_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // ************************************************************
   // Two flop chain; first stage feeds only the second
   // ************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         // Idle pin levels, so no false edge or level follows reset
         meta_q   <= rst_val_in;
         sync_out <= rst_val_in;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : wss_sync

// ===== src/wss_top.sv
`timescale 1ns/100ps
module wss_top
   import wss_pkg::*;
#(
   parameter int unsigned WAKE_CYC = WSS_WAKE_CYC
) (
   // Clock and link reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_b_in,
   // Classic Wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   output logic             wb_err_out,
   // Sideband pins
   input  wire logic        card_present_in,
   input  wire logic        radio_kill_n_in,
   input  wire logic        power_backoff_req_in,
   input  wire logic        clkreq_n_in,
   output logic             clkreq_n_out,
   output logic             clkreq_n_oe_out,
   output logic             pewake_n_out,
   output logic             pewake_n_oe_out,
   output logic             rf_on_lamp_n_out,
   output logic             rf_on_lamp_n_oe_out,
   output logic             host_wake_pulse_n_out,
   // Status to the rest of the modem
   output logic             core_reset_out,
   output logic             card_present_out,
   output logic             flight_mode_out,
   output logic             tx_power_limit_out,
   output logic             irq_out
);

   // ************************************************************
   // Declarations
   // ************************************************************
   wss_cfg_t     cfg_q,  cfg_d;     // Stored setting, survives link reset
   wss_cfg_t     act_q;             // Setting in force since last restart
   logic [3:0]   ctrl_q;
   logic [WSS_EV_W-1:0] irq_q, mask_q, ev;
   wss_sense_t   sense;
   logic [3:0]   sync_raw;
   logic         card_q, kill_q, boff_q, clk_q;
   logic         boot_q;
   // The core has no reset pin of its own; this flag marks power-up
   logic         pwr_up_q = 1'b0;
   wss_wake_st_t wst_q, wst_d;
   logic [31:0]  wcnt_q;
   logic         restart_q;

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   wss_sync #(.W(4)) u_sync (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .async_in   ({card_present_in, radio_kill_n_in, power_backoff_req_in, clkreq_n_in}),
      .rst_val_in (4'hf),
      .sync_out   (sync_raw)
   );

   // Polarity and enables applied after the sync chain
   wire card_lvl   = sync_raw[3] ^ act_q.invert;
   wire kill_lvl   = act_q.kill_en & ~sync_raw[2];
   wire boff_lvl   = ~sync_raw[1];
   wire clk_ext_lo = ~sync_raw[0];

   // ************************************************************
   // Bus decode
   // ************************************************************
   wire bus_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
   wire hit_cfg  = wb_adr_in == WSS_CFG_OFS;
   wire hit_ctrl = wb_adr_in == WSS_CTRL_OFS;
   wire hit_stat = wb_adr_in == WSS_STAT_OFS;
   wire hit_irq  = wb_adr_in == WSS_IRQ_OFS;
   wire hit_mask = wb_adr_in == WSS_MASK_OFS;
   wire hit_cmd  = wb_adr_in == WSS_CMD_OFS;
   wire hit_any  = hit_cfg | hit_ctrl | hit_stat | hit_irq | hit_mask | hit_cmd;
   wire wr_ok    = bus_req & wb_we_in & wb_sel_in[0];
   wire wr_cfg   = wr_ok & hit_cfg;
   wire wr_ctrl  = wr_ok & hit_ctrl;
   wire wr_mask  = wr_ok & hit_mask;
   wire wr_cmd   = wr_ok & hit_cmd;
   wire rd_irq   = bus_req & ~wb_we_in & hit_irq;
   wire cmd_wake = wr_cmd & wb_dat_in[WSS_CMD_WAKE];
   wire cmd_rst  = wr_cmd & wb_dat_in[WSS_CMD_RESTART];

   assign sense = '{card_present: card_q, radio_off: kill_q,
                    backoff: boff_q, clkreq_line: clk_q};

   wire [31:0] rd_mux =
      hit_cfg  ? {28'h0, cfg_q}  :
      hit_ctrl ? {28'h0, ctrl_q} :
      hit_stat ? {27'h0, boot_q, sense} :
      hit_irq  ? {26'h0, irq_q}  :
      hit_mask ? {26'h0, mask_q} : 32'h0;

   // Stored setting keeps its value across a link reset
   always_comb begin
      cfg_d = cfg_q;
      if (wr_cfg) begin
         cfg_d = wss_cfg_t'(wb_dat_in[3:0]);
      end
   end

   // ************************************************************
   // Whole-module restart: core dump plus link reset, or command
   // ************************************************************
   wire full_rst = (~rst_b_in & ctrl_q[WSS_CTRL_CDUMP]) | restart_q;

   // Power-up flag: low only until the first clock edge
   always_ff @(posedge sys_clk_in) begin
      pwr_up_q <= 1'b1;
   end

   // Settings live in the module core: only power-up and a full restart load them
   always_ff @(posedge sys_clk_in) begin
      if (~pwr_up_q) begin
         act_q <= wss_cfg_t'(WSS_CFG_RST);
      end else if (full_rst | ~boot_q) begin
         act_q <= cfg_q;
      end
   end

   // Stored setting takes its default at power-up only, so a restart keeps it
   always_ff @(posedge sys_clk_in) begin
      if (~pwr_up_q) begin
         cfg_q <= wss_cfg_t'(WSS_CFG_RST);
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // Boot flag: low for the first cycle after power-up and after full restart
   always_ff @(posedge sys_clk_in) begin
      if (~pwr_up_q | full_rst) begin
         boot_q    <= 1'b0;
         restart_q <= 1'b0;
      end else begin
         boot_q    <= 1'b1;
         restart_q <= cmd_rst & rst_b_in;
      end
   end

   // ************************************************************
   // Link-side registers, cleared by the link reset
   // ************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         wb_ack_out <= 1'b0;
         wb_err_out <= 1'b0;
         wb_dat_out <= 32'h0;
         mask_q     <= '0;
      end else begin
         wb_ack_out <= bus_req & hit_any;
         wb_err_out <= bus_req & ~hit_any;
         wb_dat_out <= (bus_req & ~wb_we_in) ? rd_mux : 32'h0;
         if (wr_mask) begin
            mask_q <= wb_dat_in[WSS_EV_W-1:0];
         end
      end
   end

   // Control bits; cleared by the link reset and by the full restart
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in | full_rst) begin
         ctrl_q <= WSS_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= wb_dat_in[3:0];
      end
   end

   // ************************************************************
   // Sensed state
   // ************************************************************
   // With hot-plug off, the card level is taken once after restart
   wire card_take = act_q.hotplug | ~boot_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         kill_q <= 1'b0;
         boff_q <= 1'b0;
         clk_q  <= 1'b0;
      end else begin
         kill_q <= kill_lvl;
         boff_q <= boff_lvl;
         clk_q  <= clk_ext_lo;
      end
   end

   // Card state is core state: not lost on link reset
   always_ff @(posedge sys_clk_in) begin
      if (card_take) begin
         card_q <= card_lvl;
      end
   end

   // ************************************************************
   // Interrupt status, sticky; read clears, new event wins
   // ************************************************************
   assign ev[WSS_EV_INSERT]  = card_take & boot_q & card_lvl & ~card_q;
   assign ev[WSS_EV_REMOVE]  = card_take & boot_q & ~card_lvl & card_q;
   assign ev[WSS_EV_KILL]    = kill_lvl ^ kill_q;
   assign ev[WSS_EV_BACKOFF] = boff_lvl ^ boff_q;
   assign ev[WSS_EV_CLKREQ]  = clk_ext_lo & ~clk_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         irq_q <= '0;
      end else begin
         irq_q <= (rd_irq ? '0 : irq_q) | ev;
      end
   end

   // ************************************************************
   // Host wake pulse
   // ************************************************************
   wire wcnt_done = wcnt_q == WAKE_CYC - 1;

   always_comb begin
      wst_d = wst_q;
      unique case (wst_q)
         WSS_W_IDLE: begin
            if (cmd_wake & act_q.wake_en) begin
               wst_d = WSS_W_PULSE;
            end
         end
         WSS_W_PULSE: begin
            if (wcnt_done) begin
               wst_d = WSS_W_IDLE;
            end
         end
         default: wst_d = WSS_W_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         wst_q  <= WSS_W_IDLE;
         wcnt_q <= 32'h0;
      end else begin
         wst_q  <= wst_d;
         wcnt_q <= (wst_q == WSS_W_PULSE) ? wcnt_q + 32'h1 : 32'h0;
      end
   end

   // ************************************************************
   // Registered pin and status outputs
   // ************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         clkreq_n_oe_out       <= 1'b0;
         pewake_n_oe_out       <= 1'b0;
         rf_on_lamp_n_oe_out   <= 1'b0;
         host_wake_pulse_n_out <= 1'b1;
         flight_mode_out       <= 1'b0;
         tx_power_limit_out    <= 1'b0;
         irq_out               <= 1'b0;
         card_present_out      <= 1'b0;
      end else begin
         clkreq_n_oe_out       <= ctrl_q[WSS_CTRL_CLKREQ];
         pewake_n_oe_out       <= ctrl_q[WSS_CTRL_PEWAKE];
         rf_on_lamp_n_oe_out   <= ctrl_q[WSS_CTRL_RF_ON] & ~kill_q;
         host_wake_pulse_n_out <= wst_d != WSS_W_PULSE;
         flight_mode_out       <= kill_q;
         tx_power_limit_out    <= boff_q;
         irq_out               <= |(irq_q & mask_q);
         card_present_out      <= card_q;
      end
   end

   // Open-drain lines only ever sink
   always_ff @(posedge sys_clk_in) begin
      clkreq_n_out     <= 1'b0;
      pewake_n_out     <= 1'b0;
      rf_on_lamp_n_out <= 1'b0;
      core_reset_out   <= full_rst;
   end

endmodule : wss_top

// ===== testbench/wss_checker.sv
`timescale 1ns/100ps
module wss_checker #(
   parameter int unsigned WAKE_CYC = 20
) (
   // Clock, reset and bus answer
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic wb_ack_out,
   // Sideband pins and status
   input wire logic power_backoff_req_in,
   input wire logic radio_kill_n_in,
   input wire logic clkreq_n_out,
   input wire logic clkreq_n_oe_out,
   input wire logic pewake_n_out,
   input wire logic pewake_n_oe_out,
   input wire logic rf_on_lamp_n_out,
   input wire logic rf_on_lamp_n_oe_out,
   input wire logic host_wake_pulse_n_out,
   input wire logic flight_mode_out,
   input wire logic tx_power_limit_out,
   input wire logic irq_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   // Cycles the wake output has been low so far
   logic [31:0] low_cnt_q;
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in || host_wake_pulse_n_out) low_cnt_q <= 32'h0;
      else low_cnt_q <= low_cnt_q + 32'h1;
   end

   a_reset_quiet:
   assert property (disable iff (1'b0) !rst_b_in |=> !wb_ack_out && !clkreq_n_oe_out
      && !pewake_n_oe_out && host_wake_pulse_n_out && !irq_out && !flight_mode_out)
      else $error("outputs not quiet in link reset");
   a_pins_sink_low:
   assert property (!clkreq_n_out && !pewake_n_out && !rf_on_lamp_n_out)
      else $error("open drain pin drives high");
   a_lamp_dark_flight:
   assert property (flight_mode_out [*2] |-> !rf_on_lamp_n_oe_out)
      else $error("lamp lit in flight mode");
   a_limit_when_low:
   assert property ((!power_backoff_req_in) [*6] |-> tx_power_limit_out)
      else $error("power not limited while backoff low");
   a_limit_when_high:
   assert property (power_backoff_req_in [*6] |-> !tx_power_limit_out)
      else $error("power limited while backoff high");
   a_kill_released:
   assert property (radio_kill_n_in [*6] |-> !flight_mode_out)
      else $error("flight mode with radio kill high");
   a_limit_synced:
   assert property ($rose(tx_power_limit_out) |-> !$past(power_backoff_req_in, 2))
      else $error("backoff used without synchroniser delay");
   a_wake_length:
   assert property ($rose(host_wake_pulse_n_out) |-> low_cnt_q == WAKE_CYC)
      else $error("wake pulse length wrong");
   a_wake_from_cmd:
   assert property ($fell(host_wake_pulse_n_out) |->
      wb_ack_out || $past(wb_ack_out) || $past(wb_ack_out, 2))
      else $error("wake pulse without command");

   c_wake_pulse: cover property ($rose(host_wake_pulse_n_out));
   c_flight: cover property ($rose(flight_mode_out));
   c_irq: cover property ($rose(irq_out));
endmodule : wss_checker

bind wss_top wss_checker #(.WAKE_CYC(WAKE_CYC)) u_chk (.*);

// ===== testbench/wss_partner.sv
`timescale 1ns/100ps
module wss_partner (
   // Levels chosen by the bench: card, kill, backoff, host pull
   input  wire logic [3:0] lvl_in,
   input  wire logic       clkreq_oe_in,
   // Pins as the slot, sensor and host present them
   output logic            card_out,
   output logic            kill_n_out,
   output logic            backoff_out,
   output logic            clkreq_line_out
);
   // Slot switch and sensor levels
   assign card_out        = lvl_in[3];
   assign kill_n_out      = lvl_in[2];
   assign backoff_out     = lvl_in[1];
   // Wired-low line with platform pull-up, either side may pull it
   assign clkreq_line_out = !(clkreq_oe_in || lvl_in[0]);
endmodule : wss_partner

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb;
   import wss_pkg::*;
   localparam int unsigned WC = 20;
   logic        clk, rst_b, wb_cyc, wb_stb, wb_we, ack, err, cr_line, cr_oe, pw_oe, lp_oe;
   logic        hwp, card_out, flight, limit, irq, card, kill_n, boff, core_rst;
   logic [7:0]  wb_adr;
   logic [31:0] wb_dat_w, wb_dat_r;
   logic [3:0]  pin_lvl;
   logic [33:0] exp_q[$], mon_e;
   logic [15:0] lfsr_q;
   int          bad_count, num_checks, low_n, cr_n;

   wss_partner far (.lvl_in(pin_lvl), .clkreq_oe_in(cr_oe), .card_out(card),
      .kill_n_out(kill_n), .backoff_out(boff), .clkreq_line_out(cr_line));
   wss_top #(.WAKE_CYC(WC)) dut (.sys_clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(wb_cyc),
      .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hf),
      .wb_dat_in(wb_dat_w), .wb_dat_out(wb_dat_r), .wb_ack_out(ack), .wb_err_out(err),
      .card_present_in(card), .radio_kill_n_in(kill_n), .power_backoff_req_in(boff),
      .clkreq_n_in(cr_line), .clkreq_n_out(), .clkreq_n_oe_out(cr_oe), .pewake_n_out(),
      .pewake_n_oe_out(pw_oe), .rf_on_lamp_n_out(), .rf_on_lamp_n_oe_out(lp_oe),
      .host_wake_pulse_n_out(hwp), .core_reset_out(core_rst), .card_present_out(card_out),
      .flight_mode_out(flight), .tx_power_limit_out(limit), .irq_out(irq));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   task automatic wt(input int c);
      repeat (c) @(posedge clk);
   endtask : wt

   // Classic cycle; e holds read-check flag, error flag and data
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] e);
      int n;
      exp_q.push_back(e);
      @(posedge clk);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, w, a, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      {wb_cyc, wb_stb} <= 2'b00;
      if (n >= 20) begin
         bad_count++;
         stop_test();
      end
   endtask : bus

   // New settings only apply on restart; clear events it raises
   task automatic cfg(input logic [3:0] c);
      bus(1'b1, WSS_CFG_OFS, {28'h0, c}, '0);
      bus(1'b1, WSS_CMD_OFS, 32'h2, '0);
      wt(6);
      bus(1'b0, WSS_IRQ_OFS, '0, '0);
   endtask : cfg

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Answers are matched to the oldest note; wake low cycles are counted
   always @(posedge clk) begin
      if (hwp === 1'b0) low_n++;
      if (core_rst === 1'b1) cr_n++;
      if (ack === 1'b1 || err === 1'b1) begin
         mon_e = exp_q.pop_front();
         chk(err, mon_e[32]);
         if (mon_e[33]) chk(wb_dat_r, mon_e[31:0]);
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
      {pin_lvl, rst_b, lfsr_q} = {4'he, 1'b0, 16'he635};
      {bad_count, num_checks, low_n, cr_n} = '0;
      wt(2);
      chk({hwp, cr_oe, pw_oe, lp_oe, irq}, 5'h10);
      rst_b <= 1'b1;
      cfg(4'h1);
      bus(1'b0, WSS_CFG_OFS, '0, {2'b10, 32'h1});
      bus(1'b0, WSS_CTRL_OFS, '0, {2'b10, 32'h0});
      bus(1'b0, 8'h18, '0, {2'b01, 32'h0});
      bus(1'b1, WSS_MASK_OFS, 32'h1f, '0);
      pin_lvl[3] <= 1'b0;
      wt(5);
      chk({card_out, irq}, 2'b01);
      bus(1'b0, WSS_IRQ_OFS, '0, {2'b10, 32'h2});
      bus(1'b1, WSS_MASK_OFS, 32'h0, '0);
      pin_lvl[3] <= 1'b1;
      wt(5);
      chk({card_out, irq}, 2'b10);
      bus(1'b0, WSS_IRQ_OFS, '0, {2'b10, 32'h1});
      bus(1'b1, WSS_MASK_OFS, 32'h1f, '0);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, WSS_CTRL_OFS, 32'h1 << i, '0);
         wt(2);
         chk({pw_oe, cr_oe, lp_oe}, 3'h1 << i);
      end
      bus(1'b1, WSS_CTRL_OFS, '0, '0);
      bus(1'b0, WSS_IRQ_OFS, '0, '0);
      pin_lvl[0] <= 1'b1;
      wt(5);
      bus(1'b0, WSS_IRQ_OFS, '0, {2'b10, 32'h10});
      pin_lvl[0] <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         lfsr_q = lfsr(lfsr_q);
         pin_lvl[1] <= lfsr_q[0];
         wt(5);
         chk(limit, !lfsr_q[0]);
      end
      pin_lvl[2:1] <= 2'b01;
      wt(5);
      chk(flight, 0);
      cfg(4'h9);
      bus(1'b1, WSS_CTRL_OFS, 32'h1, '0);
      wt(2);
      chk({flight, lp_oe}, 2'b10);
      pin_lvl[2] <= 1'b1;
      wt(5);
      chk({flight, lp_oe}, 2'b01);
      cfg(4'h3);
      chk(card_out, 0);
      pin_lvl[3] <= 1'b0;
      wt(5);
      chk(card_out, 1);
      cfg(4'h2);
      pin_lvl[3] <= 1'b1;
      wt(5);
      chk(card_out, 1);
      bus(1'b1, WSS_CFG_OFS, 32'h5, '0);
      low_n = 0;
      bus(1'b1, WSS_CMD_OFS, 32'h1, '0);
      wt(WC + 5);
      chk(low_n, 0);
      bus(1'b1, WSS_CTRL_OFS, 32'h8, '0);
      rst_b <= 1'b0;
      wt(3);
      rst_b <= 1'b1;
      wt(5);
      bus(1'b0, WSS_CTRL_OFS, '0, {2'b10, 32'h0});
      chk(card_out, 1);
      low_n = 0;
      bus(1'b1, WSS_CMD_OFS, 32'h1, '0);
      wt(WC + 10);
      chk(low_n, WC);
      // Four command restarts plus one core-dump link reset, one cycle each
      chk(cr_n, 5);
      stop_test();
   end
endmodule : tb
